// ### inc/secd_pkg.sv
// secd_pkg: constants, types and code layout helpers for the secded codec
// Operation
// - zero syndrome means no error; detected, corrected and fatal all low
// - top syndrome bit set, low bits naming a data bit: single error, flip that bit, detected+corrected
// - syndrome bits below the top bit give the faulty bit position
// - nonzero syndrome with top bit clear: detected+fatal, corrected low, no fix
// - single error in a parity bit raises no flags; data still correct
// - more than two errors: odd count acts single, even count acts double
// - errors wider than two bits need not be detected
// - latency 1: outputs registered, result one rising edge after input
// - latency 2: inputs and outputs registered, one edge later than latency 1
// - no pipelining: outputs follow inputs combinationally
// - asynchronous clear empties the state registers, clock enable back to 1, at once, without a clock edge
// - clear and clock enable exist only when pipelining is selected
// - clock enable low: no input load, no output update
// - encoder outputs data bits unchanged plus generated parity bits
// - encoder data width from 2 to 64 bits
// - decoder code width 6 to 72, never 9, 17, 33 or 65
// - decoder computes syndrome, outputs raw data and status flags
// - parity count 3+1, 4+1, 5+1, 6+1 or 7+1 by data width
// - even parity; extra top bit makes whole code word even in ones
package secd_pkg;

  localparam int DATA_W_DEF = 64;
  localparam int LAT_DEF    = 1;
  localparam int DIN_W      = 96;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_DIN0  = 8'h04;
  localparam logic [7:0] ADR_DIN1  = 8'h08;
  localparam logic [7:0] ADR_DIN2  = 8'h0C;
  localparam logic [7:0] ADR_DOUT0 = 8'h10;
  localparam logic [7:0] ADR_DOUT1 = 8'h14;
  localparam logic [7:0] ADR_DOUT2 = 8'h18;
  localparam logic [7:0] ADR_STAT  = 8'h1C;

  // field positions
  localparam int CTRL_MODE_BIT  = 0;
  localparam int CTRL_CLKEN_BIT = 1;
  localparam int STAT_DET_BIT   = 0;
  localparam int STAT_COR_BIT   = 1;
  localparam int STAT_FAT_BIT   = 2;

  // reset values
  localparam logic       CLKEN_RST = 1'b1;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  typedef enum logic {SECD_ENC, SECD_DEC} secd_mode_t;

  // hamming parity count: smallest p with 2^p >= data + p + 1
  function automatic int par_bits(input int dw);
    for (int p = 3; p < 8; p++)
      if ((1 << p) >= dw + p + 1)
        return p;
    return 7;
  endfunction

  // hamming position of data bit i: skips powers of two
  function automatic int hpos(input int i);
    int c;
    c = 0;
    for (int n = 3; n < 128; n++)
      if ((n & (n - 1)) != 0)
      begin
        if (c == i)
          return n;
        c++;
      end
    return 0;
  endfunction

endpackage

// ### rtl/secd_core.sv
// secd_core: combinational secded encode and decode for one word
`timescale 1ns/1ps
module secd_core #(
  parameter int DATA_W = secd_pkg::DATA_W_DEF,
  parameter int P      = secd_pkg::par_bits(DATA_W),
  parameter int CW     = DATA_W + P + 1
) (
  input  wire secd_pkg::secd_mode_t i_mode,
  input  wire logic [CW-1:0]        i_cw,
  output logic      [CW-1:0]        o_cw,
  output logic      [P:0]           o_synd,
  output logic                      o_det,
  output logic                      o_cor,
  output logic                      o_fat
);
  import secd_pkg::*;

  logic [DATA_W-1:0] data;
  logic [DATA_W-1:0] fixed;
  logic [P-1:0]      par;
  logic [P-1:0]      synd_lo;
  logic              odd;
  logic              hit;

  // parity per hamming position, syndrome and single-bit repair
  always_comb
  begin
    data  = i_cw[DATA_W-1:0];
    par   = '0;
    hit   = 1'b0;
    for (int i = 0; i < DATA_W; i++)
      for (int j = 0; j < P; j++)
        if (1'(hpos(i) >> j))
          par[j] = par[j] ^ data[i];
    synd_lo = par ^ i_cw[DATA_W +: P];
    // odd error counts flip the overall check, even ones leave it clear
    odd     = ^i_cw;
    o_synd  = {odd, synd_lo};
    fixed   = data;
    // lower syndrome bits name the hamming position to invert
    for (int i = 0; i < DATA_W; i++)
      if (odd && synd_lo == P'(hpos(i)))
      begin
        fixed[i] = ~fixed[i];
        hit      = 1'b1;
      end
    o_det = 1'b0;
    o_cor = 1'b0;
    o_fat = 1'b0;
    if (i_mode == SECD_ENC)
    begin
      // data kept as is, parity above it, even overall bit on top
      o_cw = {^{par, data}, par, data};
    end
    else
    begin
      // decoder hands back only the raw data, zero above it
      o_cw = CW'(fixed);
      if (odd)
      begin
        // flags only when the repaired bit is a data bit
        o_det = hit;
        o_cor = hit;
      end
      else if (synd_lo != '0)
      begin
        // double error: report fatal, leave data untouched
        o_cw  = CW'(data);
        o_det = 1'b1;
        o_fat = 1'b1;
      end
      // all-zero syndrome leaves every flag low
    end
  end

endmodule

// ### rtl/secd_ecc_top.sv
// secd_ecc_top: wishbone-mapped secded codec with optional pipelining
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module secd_ecc_top #(
  parameter int DATA_W  = secd_pkg::DATA_W_DEF,
  parameter int LATENCY = secd_pkg::LAT_DEF
) (
  input  wire  logic        I_CLK,
  input  wire  logic        I_RST_N,
  input  wire  logic        I_ACLR,
  input  wire  logic        I_WB_CYC,
  input  wire  logic        I_WB_STB,
  input  wire  logic        I_WB_WE,
  input  wire  logic [7:0]  I_WB_ADR,
  input  wire  logic [3:0]  I_WB_SEL,
  input  wire  logic [31:0] I_WB_DAT,
  output logic       [31:0] O_WB_DAT,
  output logic              O_WB_ACK
);
  import secd_pkg::*;

  localparam int P  = par_bits(DATA_W);
  localparam int CW = DATA_W + P + 1;
  localparam logic HAS_PIPE = (LATENCY != 0);

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdat;
    secd_mode_t       mode;
    logic             clken;
    logic [DIN_W-1:0] din;
    secd_mode_t       in_mode;
    logic [CW-1:0]    in_cw;
    logic [CW-1:0]    out_cw;
    logic             out_det;
    logic             out_cor;
    logic             out_fat;
  } secd_st_t;

  secd_st_t      st_reg;
  secd_st_t      st_next;
  logic [1:0]    rsync_reg;
  logic          rst_n;
  logic          aclr_eff;
  logic          req;
  secd_mode_t    core_mode;
  logic [CW-1:0] core_in;
  logic [CW-1:0] core_cw;
  logic [P:0]    core_synd;
  logic          core_det;
  logic          core_cor;
  logic          core_fat;
  logic [CW-1:0] view_cw;
  logic          view_det;
  logic          view_cor;
  logic          view_fat;
  logic [DIN_W-1:0] view_wide;

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  // release is synchronised so no flop sees a ragged reset edge
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rsync_reg <= 2'b00;
    else
      rsync_reg <= {rsync_reg[0], 1'b1};
  end

  assign rst_n = rsync_reg[1];

  // an unpipelined build has no clear; the port is simply ignored
  assign aclr_eff = HAS_PIPE & I_ACLR;

  ////////////////////////////////////////////////////////////////////////////
  // codec and output view

  // latency 2 feeds the codec from the input register
  assign core_mode = (LATENCY == 2) ? st_reg.in_mode : st_reg.mode;
  assign core_in   = (LATENCY == 2) ? st_reg.in_cw : st_reg.din[CW-1:0];

  secd_core #(
    .DATA_W (DATA_W),
    .P      (P),
    .CW     (CW)
  ) u_core (
    .i_mode (core_mode),
    .i_cw   (core_in),
    .o_cw   (core_cw),
    .o_synd (core_synd),
    .o_det  (core_det),
    .o_cor  (core_cor),
    .o_fat  (core_fat)
  );

  // without pipelining software reads the codec result directly
  assign view_cw   = HAS_PIPE ? st_reg.out_cw  : core_cw;
  assign view_det  = HAS_PIPE ? st_reg.out_det : core_det;
  assign view_cor  = HAS_PIPE ? st_reg.out_cor : core_cor;
  assign view_fat  = HAS_PIPE ? st_reg.out_fat : core_fat;
  assign view_wide = DIN_W'(view_cw);

  assign req = I_WB_CYC & I_WB_STB;

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = new_w[8*b +: 8];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_next = st_reg;
    // ack rises one cycle after the request and drops right after
    st_next.ack = req & ~st_reg.ack;
    if (req && !st_reg.ack && !I_WB_WE)
    begin
      unique case (I_WB_ADR)
        ADR_CTRL:
          st_next.rdat = {30'h0000_0000, st_reg.clken, st_reg.mode == SECD_DEC};
        ADR_DIN0:  st_next.rdat = st_reg.din[31:0];
        ADR_DIN1:  st_next.rdat = st_reg.din[63:32];
        ADR_DIN2:  st_next.rdat = st_reg.din[95:64];
        ADR_DOUT0: st_next.rdat = view_wide[31:0];
        ADR_DOUT1: st_next.rdat = view_wide[63:32];
        ADR_DOUT2: st_next.rdat = view_wide[95:64];
        ADR_STAT:  st_next.rdat = {29'h0000_0000, view_fat, view_cor, view_det};
        default:   st_next.rdat = RD_ZERO;
      endcase
    end
    // writes land on the edge where the master sees ack
    if (req && st_reg.ack && I_WB_WE)
    begin
      unique case (I_WB_ADR)
        ADR_CTRL:
        begin
          if (I_WB_SEL[0])
          begin
            st_next.mode  = I_WB_DAT[CTRL_MODE_BIT] ? SECD_DEC : SECD_ENC;
            st_next.clken = I_WB_DAT[CTRL_CLKEN_BIT];
          end
        end
        ADR_DIN0: st_next.din[31:0]  = lane_merge(st_reg.din[31:0], I_WB_DAT, I_WB_SEL);
        ADR_DIN1: st_next.din[63:32] = lane_merge(st_reg.din[63:32], I_WB_DAT, I_WB_SEL);
        ADR_DIN2: st_next.din[95:64] = lane_merge(st_reg.din[95:64], I_WB_DAT, I_WB_SEL);
        default:  st_next.din = st_reg.din;
      endcase
    end
    // a low enable freezes both pipeline stages
    if (st_reg.clken)
    begin
      // input stage, used only when latency is 2
      st_next.in_mode = st_reg.mode;
      st_next.in_cw   = st_reg.din[CW-1:0];
      // output stage carries data and flags of one word together
      st_next.out_cw  = core_cw;
      st_next.out_det = core_det;
      st_next.out_cor = core_cor;
      st_next.out_fat = core_fat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // the clear empties the block, clken back to 1, at once, not at the next edge
  always_ff @(posedge I_CLK or negedge rst_n or posedge aclr_eff)
  begin
    if (!rst_n || aclr_eff)
    begin
      st_reg       <= '0;
      st_reg.clken <= CLKEN_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign O_WB_DAT = st_reg.rdat;
  assign O_WB_ACK = st_reg.ack;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_clean_flags: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_DEC && core_synd == '0) |-> !core_det && !core_cor && !core_fat)
    else $error("flags raised on a clean word");

  a_single_fix: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_DEC && core_cor) |-> core_det && !core_fat && core_synd[P])
    else $error("single error flags inconsistent");

  a_flip_one: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_DEC && core_cor)
      |-> $onehot(core_cw[DATA_W-1:0] ^ core_in[DATA_W-1:0]))
    else $error("correction did not flip exactly one bit");

  a_double_flag: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_DEC && !core_synd[P] && core_synd != '0)
      |-> core_det && core_fat && !core_cor
          && core_cw[DATA_W-1:0] == core_in[DATA_W-1:0])
    else $error("double error not reported as fatal");

  a_parity_quiet: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_DEC && core_synd[P] && !core_det)
      |-> core_cw[DATA_W-1:0] == core_in[DATA_W-1:0] && !core_cor)
    else $error("parity-bit error changed data or flags");

  a_enc_even: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_ENC)
      |-> (^core_cw) == 1'b0 && core_cw[DATA_W-1:0] == core_in[DATA_W-1:0])
    else $error("encoder word not even or data altered");

  a_width_range: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    DATA_W >= 2 && DATA_W <= 64)
    else $error("data width out of range");

  a_code_width: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    CW >= 6 && CW <= 72 && CW != 9 && CW != 17 && CW != 33 && CW != 65)
    else $error("code word width not supported");

  a_par_count: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    P == ((DATA_W <= 4) ? 3 : (DATA_W <= 11) ? 4 : (DATA_W <= 26) ? 5
          : (DATA_W <= 57) ? 6 : 7))
    else $error("parity bit count does not match data width");

  a_enc_quiet: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_ENC) |-> !core_det && !core_cor && !core_fat)
    else $error("encoder raised a status flag");

  a_dec_raw: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_DEC) |-> core_cw[CW-1:DATA_W] == '0)
    else $error("decoder result has bits above the data");

  a_odd_single: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (core_mode == SECD_DEC && core_synd[P]) |-> !core_fat)
    else $error("odd error count reported as fatal");

  a_flags_step: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    st_reg.clken |=> st_reg.out_cw == $past(core_cw)
                     && st_reg.out_det == $past(core_det)
                     && st_reg.out_cor == $past(core_cor) && st_reg.out_fat == $past(core_fat))
    else $error("flags and data left the output stage apart");

  a_clken_clear: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    aclr_eff |-> st_reg.clken == CLKEN_RST && st_reg.mode == SECD_ENC && st_reg.rdat == RD_ZERO)
    else $error("clear left control or read data set");

  // bus answer one cycle later
  a_ack_answer: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (req && !O_WB_ACK) |=> O_WB_ACK)
    else $error("request not acknowledged on the next cycle");

  // unmapped reads return zero
  a_rd_unmapped: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (req && !O_WB_ACK && !I_WB_WE && (I_WB_ADR[1:0] != 2'b00 || I_WB_ADR > ADR_STAT))
      |=> O_WB_DAT == RD_ZERO)
    else $error("unmapped read returned data");

  // read-only writes change nothing
  a_wr_ignored: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    (req && O_WB_ACK && I_WB_WE && I_WB_ADR >= ADR_DOUT0)
      |=> $stable(st_reg.din) && $stable(st_reg.mode) && $stable(st_reg.clken))
    else $error("write to a read-only place changed state");

  a_ack_pulse: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held for more than one cycle");

  a_aclr_clear: assert property (
    @(posedge I_CLK) disable iff (!rst_n)
    aclr_eff |-> st_reg.out_cw == '0 && !st_reg.ack && st_reg.din == '0)
    else $error("clear left a register set");

  a_hold_off: assert property (
    @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
    !st_reg.clken |=> $stable(st_reg.out_cw) && $stable(st_reg.in_cw)
                      && $stable(st_reg.out_det))
    else $error("pipeline moved while enable low");

  if (LATENCY == 0)
  begin : g_lat0
    a_lat_zero: assert property (
      @(posedge I_CLK) disable iff (!rst_n)
      view_cw == core_cw && view_det == core_det && view_fat == core_fat)
      else $error("unpipelined output not combinational");
  end

  if (LATENCY == 1)
  begin : g_lat1
    a_lat_one: assert property (
      @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
      st_reg.clken |=> st_reg.out_cw == $past(core_cw)
                       && st_reg.out_det == $past(core_det))
      else $error("latency one output not one edge late");
  end

  if (LATENCY == 2)
  begin : g_lat2
    a_lat_two: assert property (
      @(posedge I_CLK) disable iff (!rst_n || aclr_eff)
      st_reg.clken
        |=> st_reg.in_cw == $past(st_reg.din[CW-1:0])
            && st_reg.out_cw == $past(core_cw))
      else $error("latency two pipeline misaligned");
  end

endmodule

// ### verif/secd_user.sv
// secd_user: upstream user logic that reaches the codec over classic wishbone
`timescale 1ns/1ps
module secd_user (
  input  wire logic        i_clk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [7:0]       o_adr,
  output logic [3:0]       o_sel,
  output logic [31:0]      o_dat
);
  // bus idle at time zero; all lanes enabled for every write
  initial
  begin
    o_cyc = 1'b0;
    o_stb = 1'b0;
    o_we  = 1'b0;
    o_adr = 8'h00;
    o_sel = 4'hF;
    o_dat = 32'h0000_0000;
  end

  // one classic cycle; request held until ack is sampled at a rising edge,
  // then released and the data lines inverted so stale values never match
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge i_clk);
    o_cyc <= 1'b1;
    o_stb <= 1'b1;
    o_we  <= we;
    o_adr <= adr;
    o_dat <= wd;
    do
      @(posedge i_clk);
    while (i_ack !== 1'b1);
    rd = i_dat;
    o_cyc <= 1'b0;
    o_stb <= 1'b0;
    o_we  <= 1'b0;
    o_adr <= ~adr;
    o_dat <= ~wd;
  endtask
endmodule

// ### verif/secded_ecc_codec_tb_top.sv
// secded_ecc_codec_tb_top: self-checking bench for the wishbone-mapped codec
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module secded_ecc_codec_tb_top;
  import secd_pkg::*;
  localparam int DW  = 8;
  localparam int LAT = 2;
  localparam int LIMIT = 5000;
  typedef struct {logic mode; logic [7:0] data; logic [12:0] flip;} secd_row_t;

  logic        clk;
  logic        rst_n;
  logic        aclr;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] bus_rd;
  logic        ack;
  logic [31:0] rd;
  logic [31:0] exp_d;
  logic [31:0] exp_s;
  logic [12:0] cw;
  int          fails;
  int          n_checks;
  int          cycles;
  int          cnt;

  // mode, data, flipped code bits: clean, single data, parity, double
  secd_row_t rows [10] = '{
    '{1'b0, 8'h00, 13'h0000}, '{1'b0, 8'hA5, 13'h0000}, '{1'b0, 8'hFF, 13'h0000},
    '{1'b1, 8'h3C, 13'h0000}, '{1'b1, 8'h3C, 13'h0001}, '{1'b1, 8'h3C, 13'h0080},
    '{1'b1, 8'h96, 13'h0200}, '{1'b1, 8'h96, 13'h1000}, '{1'b1, 8'h5A, 13'h0012},
    '{1'b1, 8'h5A, 13'h0408}};

  secd_ecc_top #(.DATA_W(DW), .LATENCY(LAT)) i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_ACLR(aclr), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(bus_rd), .O_WB_ACK(ack));

  secd_user i_user (
    .i_clk(clk), .i_ack(ack), .i_dat(bus_rd), .o_cyc(cyc), .o_stb(stb),
    .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));

  initial
  begin
    clk = 1'b0;
  end

  always #5 clk = ~clk;

  // reference code word, 13 bits to match the decoder width
  function automatic logic [12:0] enc(input logic [7:0] d);
    logic [12:0] c;
    int          pos;
    c = 13'h0000;
    c[7:0] = d;
    pos = 3;
    for (int i = 0; i < 8; i++)
    begin
      while ((pos & (pos - 1)) == 0)
        pos++;
      for (int j = 0; j < 4; j++)
        if (pos[j] && d[i])
          c[8 + j] = ~c[8 + j];
      pos++;
    end
    c[12] = ^c[11:0];
    return c;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    i_user.xfer(1'b1, a, d, dummy);
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d);
    i_user.xfer(1'b0, a, 32'h0000_0000, d);
  endtask

  task automatic finish_test();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard: a wait that never ends counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    fails = 0;
    n_checks = 0;
    cycles = 0;
    rst_n = 1'b0;
    aclr = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdr(ADR_CTRL, rd);
    `CHK(rd, 32'h0000_0002)
    // table: encode rows check the word, decode rows check data and flags
    foreach (rows[n])
    begin
      cw = enc(rows[n].data);
      cnt = $countones(rows[n].flip);
      wr(ADR_CTRL, {30'h0000_0000, 1'b1, rows[n].mode});
      wr(ADR_DIN0, rows[n].mode ? {19'h0_0000, cw ^ rows[n].flip} : {24'h00_0000, rows[n].data});
      // the input stage costs one more edge
      @(posedge clk);
      rdr(ADR_DOUT0, rd);
      if (!rows[n].mode)
        `CHK(rd, {19'h0_0000, cw})
      else
      begin
        exp_d = {24'h00_0000, rows[n].data ^ ((cnt % 2 == 0) ? rows[n].flip[7:0] : 8'h00)};
        exp_s = (cnt == 0) ? 32'h0000_0000 : (cnt % 2 == 0) ? 32'h0000_0005 :
                (rows[n].flip[7:0] != 8'h00) ? 32'h0000_0003 : 32'h0000_0000;
        `CHK(rd, exp_d)
        rdr(ADR_STAT, rd);
        `CHK(rd, exp_s)
      end
    end
    // four flipped data bits act as a double error
    wr(ADR_DIN0, {19'h0_0000, enc(8'h5A) ^ 13'h0017});
    @(posedge clk);
    rdr(ADR_STAT, rd);
    `CHK(rd, 32'h0000_0005)
    // clock enable low freezes the flags while a corrupt word is applied
    wr(ADR_DIN0, {19'h0_0000, enc(8'h3C)});
    wr(ADR_CTRL, 32'h0000_0001);
    wr(ADR_DIN0, {19'h0_0000, enc(8'h3C) ^ 13'h0001});
    repeat (3) @(posedge clk);
    rdr(ADR_STAT, rd);
    `CHK(rd, 32'h0000_0000)
    wr(ADR_CTRL, 32'h0000_0003);
    @(posedge clk);
    rdr(ADR_STAT, rd);
    `CHK(rd, 32'h0000_0003)
    // clear raised at one edge must empty the bus registers before the next
    @(posedge clk);
    aclr <= 1'b1;
    #1;
    `CHK(bus_rd, 32'h0000_0000)
    `CHK(ack, 1'b0)
    @(posedge clk);
    aclr <= 1'b0;
    repeat (3) @(posedge clk);
    rdr(ADR_CTRL, rd);
    `CHK(rd, 32'h0000_0002)
    rdr(ADR_STAT, rd);
    `CHK(rd, 32'h0000_0000)
    // read-only and unmapped places ignore writes; dout0 reads the zero code of the cleared input, 0x20 reads zero
    wr(ADR_DOUT0, 32'hFFFF_FFFF);
    rdr(ADR_DOUT0, rd);
    `CHK(rd, 32'h0000_0000)
    wr(8'h20, 32'hFFFF_FFFF);
    rdr(8'h20, rd);
    `CHK(rd, 32'h0000_0000)
    finish_test();
  end
endmodule
